// file: inc/shl_aux_pkg.sv
// Constants, field layouts and carrier types for the aux-register shift slice
package shl_aux_pkg;

    // Instruction word fields (bit 0 of the printed layout is the MSB here)
    localparam logic [5:0] PRIMARY_OP    = 6'h1f;   // 31
    localparam logic [9:0] XO_SAVE_IMM   = 10'h0b8; // 184
    localparam logic [9:0] XO_MERGE_IMM  = 10'h0f8; // 248
    localparam logic [9:0] XO_MERGE_REG  = 10'h0d8; // 216
    localparam int         PRIM_LSB      = 26;
    localparam int         SRC_LSB       = 21;
    localparam int         TGT_LSB       = 16;
    localparam int         AMT_LSB       = 11;
    localparam int         XO_LSB        = 1;
    localparam int         REC_BIT       = 0;
    localparam int         FIELD_W       = 5;
    localparam int         XO_W          = 10;
    localparam int         PRIM_W        = 6;
    // Amount register: count in printed bits 27-31, select in printed bit 26
    localparam int         AMT_SEL_BIT   = 5;

    // Condition field bit positions within the 4-bit field
    localparam int         CR_NEG        = 3;
    localparam int         CR_POS        = 2;
    localparam int         CR_ZERO       = 1;
    localparam int         CR_SO         = 0;

    // Register map (byte addresses)
    localparam int         REG_ADDR_W    = 4;
    localparam logic [3:0] CTRL_OFF      = 4'h0;
    localparam logic [3:0] AUX_OFF       = 4'h4;
    localparam logic [3:0] STAT_OFF      = 4'h8;
    localparam int         CTRL_LEGACY   = 0;
    localparam logic [31:0] AUX_RESET    = 32'h0000_0000;
    localparam logic [3:0] CR_RESET      = 4'h0;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_DECERR   = 2'h3;

    typedef struct packed {
        logic [31:0] instr;
        logic [31:0] src;
        logic [31:0] amt;
        logic        so;
    } issue_t;

    typedef struct packed {
        logic        wr;
        logic [4:0]  idx;
        logic [31:0] data;
        logic        cr_we;
        logic [3:0]  cr;
    } result_t;

    typedef enum logic [1:0] {
        OP_NONE      = 2'h0,
        OP_SAVE_IMM  = 2'h1,
        OP_MERGE_IMM = 2'h3,
        OP_MERGE_REG = 2'h2
    } op_t;

    typedef enum logic {
        W_COLLECT = 1'b0,
        W_RESP    = 1'b1
    } wstate_t;

endpackage : shl_aux_pkg

// file: rtl/shl_aux_unit.sv
// Left-rotate execution slice with auxiliary register and register bus
// Functional notes
// - Decode primary 31, extended 184 as immediate save-shift; record flag is low bit.
// - Decode primary 31, extended 248 as immediate merge-shift.
// - Decode primary 31, extended 216 as register merge-shift; amount register field.
// - Immediate forms take the count from the 5-bit immediate field.
// - Save-shift: rotate, store rotated word in aux, masked word to target.
// - Immediate mask: 32-N ones from the top, then N zeros.
// - Immediate merge: merge rotated word with old aux; aux gets rotated word.
// - Register form takes N from the low five bits; next bit selects merge.
// - Select clear: N zeros then ones; merge rotated word with aux.
// - Select set: N ones then zeros; merge zero word with aux.
// - Register merge form writes target only; aux untouched.
// - Record flag set updates condition field; clear leaves it alone.
// - Exception register never written; overflow enable ignored.
// - These instructions exist only when the legacy variant is active.
module shl_aux_unit
    import shl_aux_pkg::*;
#(
    parameter logic LEGACY_DEFAULT = 1'b1
) (
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // Issue from the decoder and register file
    input  wire logic                  issue_valid,
    input  wire issue_t                issue,
    // Writeback toward the register file
    output logic                       result_valid,
    output result_t                    result,
    output logic                       illegal_op,
    output logic [31:0]                aux_value,
    // AXI4-Lite write channels
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [REG_ADDR_W-1:0] awaddr,
    input  wire logic                  wvalid,
    output logic                       wready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    output logic                       bvalid,
    input  wire logic                  bready,
    output logic [1:0]                 bresp,
    // AXI4-Lite read channels
    input  wire logic                  arvalid,
    output logic                       arready,
    input  wire logic [REG_ADDR_W-1:0] araddr,
    output logic                       rvalid,
    input  wire logic                  rready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rotl32(input logic [31:0] v, input logic [4:0] n);
        logic [63:0] d;
        d = {v, v} << n;
        return d[63:32];
    endfunction : rotl32
    function automatic logic [31:0] hi_ones(input logic [4:0] n);
        return 32'hffff_ffff << n;
    endfunction : hi_ones
    function automatic logic [31:0] lo_ones(input logic [4:0] n);
        return 32'hffff_ffff >> n;
    endfunction : lo_ones
    function automatic logic [31:0] merge(input logic [31:0] a, input logic [31:0] aux,
                                          input logic [31:0] m);
        return (a & m) | (aux & ~m);
    endfunction : merge

    function automatic logic [31:0] strobe(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : strobe

    ////////////////////////////////////////////////////////////////////////
    logic           legacy_en;
    logic [31:0]    aux_reg;
    logic [3:0]     cr_last_reg;
    logic [5:0]     prim;
    logic [9:0]     xo;
    logic           ours;
    op_t            op;
    logic [4:0]     n;
    logic [31:0]    rot;
    logic [31:0]    res_next;
    logic           aux_we;
    logic [3:0]     cr_next;
    logic           bus_aux_we;
    logic           bus_ctrl_we;
    wstate_t        wstate;
    logic           aw_held;
    logic           w_held;
    logic [3:0]     aw_addr_q;
    logic [31:0]    w_data_q;
    logic [3:0]     w_strb_q;

    assign aux_value = aux_reg;

    // Decode; other opcodes are not ours and pass silently
    always_comb begin
        prim = issue.instr[PRIM_LSB +: PRIM_W];
        xo   = issue.instr[XO_LSB +: XO_W];
        ours = 1'b0;
        op   = OP_NONE;
        if (prim == PRIMARY_OP) begin
            if (xo == XO_SAVE_IMM) begin
                op   = OP_SAVE_IMM;
                ours = 1'b1;
            end else if (xo == XO_MERGE_IMM) begin
                op   = OP_MERGE_IMM;
                ours = 1'b1;
            end else if (xo == XO_MERGE_REG) begin
                op   = OP_MERGE_REG;
                ours = 1'b1;
            end
        end
        if (!legacy_en) begin
            op = OP_NONE;
        end
    end

    // Datapath
    always_comb begin
        if (op == OP_MERGE_REG) begin
            n = issue.amt[FIELD_W-1:0];
        end else begin
            n = issue.instr[AMT_LSB +: FIELD_W];
        end
        rot      = rotl32(issue.src, n);
        res_next = 32'h0000_0000;
        aux_we   = 1'b0;
        case (op)
            OP_SAVE_IMM: begin
                res_next = rot & hi_ones(n);
                aux_we   = 1'b1;
            end
            OP_MERGE_IMM: begin
                res_next = merge(rot, aux_reg, hi_ones(n));
                aux_we   = 1'b1;
            end
            OP_MERGE_REG: begin
                if (issue.amt[AMT_SEL_BIT]) begin
                    res_next = merge(32'h0000_0000, aux_reg, ~lo_ones(n));
                end else begin
                    res_next = merge(rot, aux_reg, lo_ones(n));
                end
            end
            default: begin
                res_next = 32'h0000_0000;
            end
        endcase
        // Signed compare against zero, summary overflow copied through
        cr_next[CR_NEG]  = res_next[31];
        cr_next[CR_ZERO] = (res_next == 32'h0000_0000);
        cr_next[CR_POS]  = !res_next[31] && (res_next != 32'h0000_0000);
        cr_next[CR_SO]   = issue.so;
    end

    ////////////////////////////////////////////////////////////////////////
    // Writeback; no exception-register outputs exist at all
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_valid <= 1'b0;
            result       <= '0;
            illegal_op   <= 1'b0;
        end else begin
            result_valid <= issue_valid && (op != OP_NONE);
            illegal_op   <= issue_valid && ours && !legacy_en;
            if (issue_valid && (op != OP_NONE)) begin
                result.wr    <= 1'b1;
                result.idx   <= issue.instr[TGT_LSB +: FIELD_W];
                result.data  <= res_next;
                result.cr_we <= issue.instr[REC_BIT];
                result.cr    <= cr_next;
            end else begin
                result.wr    <= 1'b0;
                result.cr_we <= 1'b0;
            end
        end
    end

    // Aux register; an instruction write wins over a bus write in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aux_reg <= AUX_RESET;
        end else if (issue_valid && aux_we) begin
            aux_reg <= rot;
        end else if (bus_aux_we) begin
            aux_reg <= strobe(aux_reg, w_data_q, w_strb_q);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cr_last_reg <= CR_RESET;
        end else if (issue_valid && (op != OP_NONE) && issue.instr[REC_BIT]) begin
            cr_last_reg <= cr_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            legacy_en <= LEGACY_DEFAULT;
        end else if (bus_ctrl_we && w_strb_q[0]) begin
            legacy_en <= w_data_q[CTRL_LEGACY];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register bus: one write and one read in flight; readies stay low until response
    assign bus_aux_we  = (wstate == W_COLLECT) && aw_held && w_held && (aw_addr_q == AUX_OFF);
    assign bus_ctrl_we = (wstate == W_COLLECT) && aw_held && w_held && (aw_addr_q == CTRL_OFF);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wstate    <= W_COLLECT;
            awready   <= 1'b1;
            wready    <= 1'b1;
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            bvalid    <= 1'b0;
            bresp     <= RESP_OKAY;
        end else begin
            case (wstate)
                W_COLLECT: begin
                    if (awvalid && awready) begin
                        aw_held   <= 1'b1;
                        awready   <= 1'b0;
                        aw_addr_q <= awaddr;
                    end
                    if (wvalid && wready) begin
                        w_held   <= 1'b1;
                        wready   <= 1'b0;
                        w_data_q <= wdata;
                        w_strb_q <= wstrb;
                    end
                    if (aw_held && w_held) begin
                        aw_held <= 1'b0;
                        w_held  <= 1'b0;
                        bvalid  <= 1'b1;
                        wstate  <= W_RESP;
                        if ((aw_addr_q == CTRL_OFF) || (aw_addr_q == AUX_OFF)
                            || (aw_addr_q == STAT_OFF)) begin
                            bresp <= RESP_OKAY;
                        end else begin
                            bresp <= RESP_DECERR;
                        end
                    end
                end
                W_RESP: begin
                    if (bready) begin
                        bvalid  <= 1'b0;
                        awready <= 1'b1;
                        wready  <= 1'b1;
                        wstate  <= W_COLLECT;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= RESP_OKAY;
            if (araddr == CTRL_OFF) begin
                rdata <= {31'h0, legacy_en};
            end else if (araddr == AUX_OFF) begin
                rdata <= aux_reg;
            end else if (araddr == STAT_OFF) begin
                rdata <= {28'h000_0000, cr_last_reg};
            end else begin
                rdata <= 32'h0000_0000;
                rresp <= RESP_DECERR;
            end
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks; helpers capture the operands of the issued instruction
    logic [31:0] h_src;
    logic [31:0] h_aux_prev;
    logic [4:0]  h_sh;
    logic [4:0]  h_rbn;
    logic [4:0]  h_idx;
    logic        h_so;

    always_ff @(posedge aclk) begin
        h_src      <= issue.src;
        h_aux_prev <= aux_reg;
        h_sh       <= issue.instr[AMT_LSB +: FIELD_W];
        h_rbn      <= issue.amt[FIELD_W-1:0];
        h_idx      <= issue.instr[TGT_LSB +: FIELD_W];
        h_so       <= issue.so;
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence save_issue;
        issue_valid && legacy_en && (prim == PRIMARY_OP) && (xo == XO_SAVE_IMM);
    endsequence
    sequence mimm_issue;
        issue_valid && legacy_en && (prim == PRIMARY_OP) && (xo == XO_MERGE_IMM);
    endsequence
    sequence mreg_issue;
        issue_valid && legacy_en && (prim == PRIMARY_OP) && (xo == XO_MERGE_REG);
    endsequence

    save_decode_a: assert property (
        save_issue |=> result_valid && result.wr && (result.idx == h_idx))
        else $error("save-shift not written back");
    imm_amount_a: assert property (
        save_issue or mimm_issue |=> aux_reg == rotl32(h_src, h_sh))
        else $error("immediate count not used");
    save_mask_a: assert property (
        save_issue |=> result.data == (aux_reg & hi_ones(h_sh)))
        else $error("save-shift mask wrong");
    merge_imm_a: assert property (
        mimm_issue |=> result.data == ((aux_reg & hi_ones(h_sh))
                                       | (h_aux_prev & ~hi_ones(h_sh))))
        else $error("immediate merge wrong");
    reg_keep_aux_a: assert property (
        mreg_issue |=> result_valid && (aux_reg == h_aux_prev))
        else $error("register merge altered aux");
    reg_clear_a: assert property (
        mreg_issue and !issue.amt[AMT_SEL_BIT] |=>
            result.data == ((rotl32(h_src, h_rbn) & lo_ones(h_rbn))
                            | (h_aux_prev & ~lo_ones(h_rbn))))
        else $error("register merge, select clear, wrong");
    reg_set_a: assert property (
        mreg_issue and issue.amt[AMT_SEL_BIT] |=>
            result.data == (h_aux_prev & lo_ones(h_rbn)))
        else $error("register merge, select set, wrong");
    rec_off_a: assert property (
        issue_valid && !issue.instr[REC_BIT] |=> !result.cr_we)
        else $error("condition written without record flag");
    cr_sign_a: assert property (
        result.cr_we |-> result.cr[CR_NEG] == result.data[31]
            && result.cr[CR_ZERO] == (result.data == 32'h0000_0000)
            && result.cr[CR_SO] == h_so)
        else $error("condition field wrong");
    legacy_off_a: assert property (
        issue_valid && !legacy_en && ours |=> illegal_op && !result_valid
            ##1 (illegal_op == $past(issue_valid && !legacy_en && ours)))
        else $error("disabled instruction executed");

endmodule : shl_aux_unit

// file: tb/issue_model.sv
// Decoder and register file stand-in that feeds the shift slice
module issue_model
    import shl_aux_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Requests from the bench
    input  wire logic        req,
    input  wire logic [31:0] req_instr,
    input  wire logic        req_so,
    // Issue toward the slice
    output issue_t           issue,
    output logic             issue_valid,
    // Writeback from the slice
    input  wire logic        result_valid,
    input  wire result_t     result
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] gpr [32];

    initial begin
        issue_valid = 1'b0;
        issue       = '0;
    end

    // Operands read one edge after the request; writebacks land on the pulse
    always @(posedge aclk) begin
        issue_valid <= aresetn & req;
        issue       <= {req_instr, gpr[req_instr[SRC_LSB +: FIELD_W]],
                        gpr[req_instr[AMT_LSB +: FIELD_W]], req_so};
        if (result_valid === 1'b1 && result.wr === 1'b1)
            gpr[result.idx] <= result.data;
    end
endmodule : issue_model

// file: tb/tb.sv
// Self-checking bench for the aux-register shift slice
`define CHK(act, exp) begin checks_done++; if ((act) !== (exp)) begin error_cnt++; \
    $display("Error at %0t: got %h expected %h", $time, act, exp); end end
module tb
    import shl_aux_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk, aresetn, req, req_so, issue_valid, result_valid, illegal_op;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] req_instr, wdata, rdata, aux_value, d, r, seed, exp_aux;
    logic [1:0]  bresp, rresp, rs;
    logic [73:0] mon_e;
    logic [9:0]  op;
    logic [3:0]  last_cr;
    issue_t      issue;
    result_t     result;
    int          error_cnt, checks_done, ill_cnt, i, k;
    logic [73:0] expq [$];
    logic [9:0]  ops [3] = '{XO_SAVE_IMM, XO_MERGE_IMM, XO_MERGE_REG};

    shl_aux_unit dut (.aclk(aclk), .aresetn(aresetn), .issue_valid(issue_valid),
        .issue(issue), .result_valid(result_valid), .result(result),
        .illegal_op(illegal_op), .aux_value(aux_value), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp));
    issue_model model (.aclk(aclk), .aresetn(aresetn), .req(req), .req_instr(req_instr),
        .req_so(req_so), .issue(issue), .issue_valid(issue_valid),
        .result_valid(result_valid), .result(result));

    always #2 aclk = ~aclk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("Checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    task automatic hang;
        $display("Error at %0t: wait ran out", $time);
        error_cnt++;
        complete_run();
    endtask : hang

    // Layout {data, aux, idx, rec, cr}
    function automatic logic [73:0] expect_op(input logic [31:0] ins, src, amt, aux,
                                              input logic so);
        logic [4:0]  n;
        logic [31:0] rot, m, dd, a;
        logic [63:0] dbl;
        n = (ins[XO_LSB +: XO_W] == XO_MERGE_REG) ? amt[4:0] : ins[AMT_LSB +: FIELD_W];
        dbl = {src, src} << n;
        rot = dbl[63:32];
        a = rot;
        m = 32'hffffffff << n;
        dd = (rot & m) | (aux & ~m);
        if (ins[XO_LSB +: XO_W] == XO_SAVE_IMM)
            dd = rot & m;
        if (ins[XO_LSB +: XO_W] == XO_MERGE_REG) begin
            a = aux;
            m = 32'hffffffff >> n;
            dd = amt[AMT_SEL_BIT] ? (aux & m) : ((rot & m) | (aux & ~m));
        end
        return {dd, a, ins[TGT_LSB +: FIELD_W], ins[REC_BIT], dd[31],
                !dd[31] && dd != 0, dd == 0, so};
    endfunction : expect_op

    task automatic issue_op(input logic [9:0] xo, input logic [4:0] s, t, a,
                            input logic rec, so, legal);
        logic [31:0] ins;
        logic [73:0] e;
        ins = {PRIMARY_OP, s, t, a, xo, rec};
        @(posedge aclk);
        req <= 1'b1;
        req_instr <= ins;
        req_so <= so;
        if (legal) begin
            e = expect_op(ins, model.gpr[s], model.gpr[a], exp_aux, so);
            exp_aux = e[41:10];
            expq.push_back(e);
        end
    endtask : issue_op

    task automatic drain;
        int n;
        @(posedge aclk);
        req <= 1'b0;
        for (n = 0; n < 20 && (expq.size() != 0 || n < 4); n++)
            @(posedge aclk);
        if (expq.size() != 0)
            hang();
    endtask : drain

    task automatic axi_wr(input logic [3:0] ad, input logic [31:0] wd, output logic [1:0] rr);
        int n;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= ad;
        wvalid <= 1'b1;
        wdata <= wd;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
            if (bvalid === 1'b1)
                break;
        end
        rr = bresp;
        bready <= 1'b0;
        if (n == 50)
            hang();
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] ad, output logic [31:0] rd, output logic [1:0] rr);
        int n;
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= ad;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready === 1'b1)
                arvalid <= 1'b0;
            if (rvalid === 1'b1)
                break;
        end
        rd = rdata;
        rr = rresp;
        rready <= 1'b0;
        if (n == 50)
            hang();
    endtask : axi_rd

    ////////////////////////////////////////////////////////////////////////////
    // Every pulse must match the oldest expectation; stray pulses are errors
    always @(posedge aclk) begin
        if (aresetn === 1'b1 && result_valid === 1'b1) begin
            if (expq.size() == 0)
                `CHK(result_valid, 1'b0)
            else begin
                mon_e = expq.pop_front();
                `CHK({result.wr, result.idx, result.data, result.cr_we}, {1'b1, mon_e[9:5], mon_e[73:42], mon_e[4]})
                `CHK(aux_value, mon_e[41:10])
                if (mon_e[4]) begin
                    `CHK(result.cr, mon_e[3:0])
                    last_cr = mon_e[3:0];
                end
            end
        end
        if (illegal_op === 1'b1)
            ill_cnt++;
    end

    initial begin
        {aclk, aresetn, req, req_so, awvalid, wvalid, bready, arvalid, rready} = '0;
        {req_instr, wdata, awaddr, araddr, exp_aux, last_cr} = '0;
        wstrb = 4'hf;
        seed = 32'h5a88;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(CTRL_OFF, d, rs);
        `CHK({rs, d}, {RESP_OKAY, 32'h0000_0001})
        axi_rd(AUX_OFF, d, rs);
        `CHK(d, AUX_RESET)
        model.gpr[4] = 32'h1234_5678;
        issue_op(XO_SAVE_IMM, 5'h04, 5'h14, 5'h14, 1'b0, 1'b0, 1'b1);
        drain();
        `CHK(result.data, 32'h6780_0000)
        axi_wr(AUX_OFF, 32'hffff_ffff, rs);
        exp_aux = 32'hffff_ffff;
        model.gpr[4] = 32'h9000_3000;
        model.gpr[5] = 32'h0000_0024;
        issue_op(XO_MERGE_IMM, 5'h04, 5'h16, 5'h03, 1'b1, 1'b0, 1'b1);
        issue_op(XO_MERGE_REG, 5'h04, 5'h17, 5'h05, 1'b1, 1'b1, 1'b1);
        drain();
        `CHK(result.data, 32'h0001_8004)
        axi_rd(AUX_OFF, d, rs);
        `CHK(d, 32'h8001_8004)
        // Neighbouring extended codes must not be taken
        issue_op(10'h0d9, 5'h04, 5'h18, 5'h05, 1'b1, 1'b0, 1'b0);
        issue_op(10'h098, 5'h04, 5'h18, 5'h05, 1'b1, 1'b0, 1'b0);
        drain();
        for (k = 0; k < 10; k++) begin
            for (i = 0; i < 16; i++)
                model.gpr[i] = $random(seed);
            model.gpr[15] = 32'h0000_003f;
            model.gpr[14] = 32'h0000_0000;
            for (i = 0; i < 30; i++) begin
                r = $random(seed);
                op = ops[r[1:0] % 2'd3];
                issue_op(op, {1'b0, r[5:2]}, {1'b1, r[9:6]},
                         (op == XO_MERGE_REG) ? {1'b0, r[13:10]} : r[14:10], r[15], r[16], 1'b1);
            end
            drain();
        end
        `CHK(ill_cnt, 0)
        axi_rd(STAT_OFF, d, rs);
        `CHK(d[3:0], last_cr)
        axi_wr(4'hc, 32'h1, rs);
        `CHK(rs, RESP_DECERR)
        axi_rd(4'hc, d, rs);
        `CHK(rs, RESP_DECERR)
        // Legacy variant off: all three codes are refused
        axi_wr(CTRL_OFF, 32'h0, rs);
        for (i = 0; i < 3; i++)
            issue_op(ops[i], 5'h01, 5'h19, 5'h02, 1'b1, 1'b0, 1'b0);
        drain();
        `CHK(ill_cnt, 3)
        axi_rd(AUX_OFF, d, rs);
        `CHK(d, exp_aux)
        axi_wr(CTRL_OFF, 32'h1, rs);
        issue_op(XO_SAVE_IMM, 5'h01, 5'h19, 5'h00, 1'b1, 1'b1, 1'b1);
        drain();
        complete_run();
    end
endmodule : tb
